// ===== core/rau_core.v
`timescale 1ns/1ps
module rau_core (
	// Clock, reset, enable
	input  wire        sys_clk_i,
	input  wire        rst_n_i,
	input  wire        ce_i,
	// Instruction port
	input  wire        cmd_valid_i,
	input  wire [3:0]  cmd_op_i,
	input  wire [7:0]  cmd_cnt_i,
	input  wire [11:0] cmd_a_i,
	input  wire [11:0] cmd_e_i,
	input  wire [11:0] cmd_k_i,
	input  wire [11:0] cmd_n_i,
	input  wire [2:0]  cmd_m_i,
	output reg         cmd_ready_o,
	output reg         done_o,
	// RAM port, read data one cycle after the address
	output reg  [11:0] ram_addr_o,
	output reg         ram_re_o,
	output reg         ram_we_o,
	output reg  [7:0]  ram_wdata_o,
	input  wire [7:0]  ram_rdata_i,
	// Receive FIFO
	input  wire        rx_valid_i,
	input  wire [7:0]  rx_data_i,
	output reg         rx_pop_o,
	// Transmit FIFO
	output reg         tx_valid_o,
	output reg  [7:0]  tx_data_o,
	input  wire        tx_ready_i
);
`include "rau_consts.vh"

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam S_IDLE = 4'h0, S_LOAD = 4'h1, S_WRITE = 4'h2, S_BYTE = 4'h3;
	localparam S_RVL  = 4'h4, S_RVW  = 4'h5, S_INCW  = 4'h6, S_KEY  = 4'h7;
	localparam S_CTR0 = 4'h8, S_BLK  = 4'h9, S_ENC   = 4'ha, S_AES  = 4'hb;
	localparam S_OUT  = 4'hc, S_DONE = 4'hd;
	localparam SB_ISSUE = 3'h0, SB_WAIT = 3'h1, SB_TAKE = 3'h2;
	localparam SB_XWAIT = 3'h3, SB_XTAKE = 3'h4, SB_PUT = 3'h5;

	reg [3:0]   state_q;
	reg [3:0]   ret_q;
	reg [2:0]   sub_q;
	reg [3:0]   op_q;
	reg [7:0]   cnt_q;
	reg [11:0]  a_q;
	reg [11:0]  e_q;
	reg [11:0]  k_q;
	reg [11:0]  n_q;
	reg [2:0]   m_q;
	reg         desc_q;
	reg         first_q;
	reg [7:0]   i_q;
	reg [8:0]   off_q;
	reg [11:0]  base_q;
	reg [4:0]   nb_q;
	reg [4:0]   idx_q;
	reg         le_q;
	reg [7:0]   tmp_q;
	reg [127:0] blk_q;
	reg [127:0] key_q;
	reg [127:0] ctr_q;
	reg [127:0] wbuf_q;
	reg [127:0] st_q;
	reg [127:0] rk_q;
	reg [7:0]   rcon_q;
	reg [3:0]   rnd_q;
	reg [7:0]   b1_q;
	reg         b1v_q;

	// ----------------------------------------
	// Address and length helpers
	// ----------------------------------------
	wire [7:0]  k_idx  = desc_q ? (cnt_q - 8'h01 - i_q) : i_q;
	wire [11:0] src_w  = a_q + {4'h0, k_idx};
	wire [11:0] dst_w  = e_q + {4'h0, k_idx};
	wire [6:0]  bpos   = {idx_q[3:0], 3'b000};
	wire [8:0]  rem_w  = {1'b0, cnt_q} - off_q;
	wire [4:0]  blen   = (rem_w > `RAU_BLK9) ? `RAU_BLK : rem_w[4:0];
	wire        fin_w  = (off_q >= {1'b0, cnt_q});
	wire [11:0] rv_base = e_q + {4'h0, cnt_q} - {4'h0, off_q[7:0]} - {7'h00, blen};
	wire [4:0]  ecb_n  = (cnt_q > {3'h0, `RAU_BLK}) ? `RAU_BLK : cnt_q[4:0];
	wire        ecb_ip = (op_q == `RAU_OP_BLOCK_ENCRYPT_IN_PLACE) || (e_q == a_q);
	wire [4:0]  tag_n  = 5'h02 << m_q[1:0];
	wire        push_w = (state_q == S_BYTE) && (sub_q == SB_PUT)
		&& (op_q == `RAU_OP_TXCP) && !b1v_q;
	wire        pop_w  = tx_valid_o && tx_ready_i;

	reg [2:0] mlut;
	always @* begin
		case (m_q[1:0])
			2'h0:    mlut = `RAU_MLUT0;
			2'h1:    mlut = `RAU_MLUT1;
			2'h2:    mlut = `RAU_MLUT2;
			default: mlut = `RAU_MLUT3;
		endcase
	end

	// flags from counter top byte, bits 5:3 replaced by mlut from m_q; counter still sits in the load buffer
	wire [127:0] b0_w = {blk_q[127:126], mlut, blk_q[122:16], 8'h00, cnt_q};

	// ----------------------------------------
	// AES-128 round, encrypt direction only
	// ----------------------------------------
	wire [159:0] sbi = {st_q, rk_q[23:0], rk_q[31:24]};
	wire [159:0] sbo;
	genvar g;
	generate
		for (g = 0; g < 20; g = g + 1) begin : g_sb
			rau_sbox u_sb (
				.a_i (sbi[8*g +: 8]),
				.s_o (sbo[8*g +: 8])
			);
		end
	endgenerate

	// Key schedule step computed alongside the round
	wire [31:0]  kt   = sbo[31:0] ^ {rcon_q, 24'h000000};
	wire [31:0]  kw0  = rk_q[127:96] ^ kt;
	wire [31:0]  kw1  = rk_q[95:64] ^ kw0;
	wire [31:0]  kw2  = rk_q[63:32] ^ kw1;
	wire [127:0] rk_n = {kw0, kw1, kw2, rk_q[31:0] ^ kw2};

	function [7:0] xt;
		input [7:0] v;
		begin
			xt = {v[6:0], 1'b0} ^ (v[7] ? `RAU_POLY : 8'h00);
		end
	endfunction

	reg [127:0] sr_w;
	reg [127:0] mx_w;
	reg [7:0]   c0, c1, c2, c3;
	integer     ci, ri;
	always @* begin
		sr_w = {128{1'b0}};
		mx_w = {128{1'b0}};
		c0 = 8'h00;
		c1 = 8'h00;
		c2 = 8'h00;
		c3 = 8'h00;
		for (ci = 0; ci < 4; ci = ci + 1)
			for (ri = 0; ri < 4; ri = ri + 1)
				sr_w[127-8*(ri+4*ci) -: 8] = sbo[159-8*(ri+4*((ci+ri)%4)) -: 8];
		for (ci = 0; ci < 4; ci = ci + 1) begin
			c0 = sr_w[127-32*ci -: 8];
			c1 = sr_w[119-32*ci -: 8];
			c2 = sr_w[111-32*ci -: 8];
			c3 = sr_w[103-32*ci -: 8];
			mx_w[127-32*ci -: 32] = {xt(c0) ^ xt(c1) ^ c1 ^ c2 ^ c3,
				c0 ^ xt(c1) ^ xt(c2) ^ c2 ^ c3,
				c0 ^ c1 ^ xt(c2) ^ xt(c3) ^ c3,
				xt(c0) ^ c0 ^ c1 ^ c2 ^ xt(c3)};
		end
	end
	wire [127:0] rnd_w = ((rnd_q == `RAU_LAST_RND) ? sr_w : mx_w) ^ rk_n;

	// ----------------------------------------
	// Sub-sequence launchers
	// ----------------------------------------
	task ld;
		input [11:0] b;
		input [4:0]  n;
		input        le;
		input [3:0]  r;
		begin
			base_q <= b;
			nb_q <= n;
			le_q <= le;
			ret_q <= r;
			idx_q <= 5'h00;
			sub_q <= SB_ISSUE;
			blk_q <= {128{1'b0}};
			state_q <= (n == 5'h00) ? r : S_LOAD;
		end
	endtask

	task wr;
		input [11:0]  b;
		input [4:0]   n;
		input         le;
		input [127:0] d;
		input [3:0]   r;
		begin
			base_q <= b;
			nb_q <= n;
			le_q <= le;
			wbuf_q <= d;
			ret_q <= r;
			idx_q <= 5'h00;
			state_q <= (n == 5'h00) ? r : S_WRITE;
		end
	endtask

	// ----------------------------------------
	// Instruction sequencer
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= S_IDLE;
			ret_q <= S_IDLE;
			sub_q <= SB_ISSUE;
			op_q <= 4'h0;
			cnt_q <= 8'h00;
			a_q <= 12'h000;
			e_q <= 12'h000;
			k_q <= 12'h000;
			n_q <= 12'h000;
			m_q <= 3'h0;
			desc_q <= 1'b0;
			first_q <= 1'b0;
			i_q <= 8'h00;
			off_q <= 9'h000;
			base_q <= 12'h000;
			nb_q <= 5'h00;
			idx_q <= 5'h00;
			le_q <= 1'b0;
			tmp_q <= 8'h00;
			blk_q <= {128{1'b0}};
			key_q <= {128{1'b0}};
			ctr_q <= {128{1'b0}};
			wbuf_q <= {128{1'b0}};
			st_q <= {128{1'b0}};
			rk_q <= {128{1'b0}};
			rcon_q <= `RAU_RCON0;
			rnd_q <= 4'h0;
			cmd_ready_o <= 1'b1;
			done_o <= 1'b0;
			ram_addr_o <= 12'h000;
			ram_re_o <= 1'b0;
			ram_we_o <= 1'b0;
			ram_wdata_o <= 8'h00;
			rx_pop_o <= 1'b0;
		end else if (ce_i) begin
			ram_re_o <= 1'b0;
			ram_we_o <= 1'b0;
			rx_pop_o <= 1'b0;
			done_o <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (cmd_valid_i) begin
					op_q <= cmd_op_i;
					cnt_q <= cmd_cnt_i;
					a_q <= cmd_a_i;
					e_q <= cmd_e_i;
					k_q <= cmd_k_i;
					n_q <= cmd_n_i;
					m_q <= cmd_m_i;
					// walk downward when destination is higher; FIFO moves keep order
					desc_q <= (cmd_e_i > cmd_a_i)
						&& ((cmd_op_i == `RAU_OP_CP) || (cmd_op_i == `RAU_OP_XCP));
					first_q <= 1'b1;
					i_q <= 8'h00;
					off_q <= 9'h000;
					sub_q <= SB_ISSUE;
					cmd_ready_o <= 1'b0;
					case (cmd_op_i)
					`RAU_OP_RXMOV, `RAU_OP_TXCP, `RAU_OP_CP, `RAU_OP_XCP: begin
						state_q <= (cmd_cnt_i == 8'h00) ? S_DONE : S_BYTE;
					end
					`RAU_OP_CPR:
						state_q <= S_RVL;
					// three byte width is not expected
					`RAU_OP_INC:
						ld(cmd_a_i, cmd_cnt_i[4:0], 1'b1, S_INCW);
					`RAU_OP_ECB, `RAU_OP_BLOCK_ENCRYPT_IN_PLACE, `RAU_OP_CTR, `RAU_OP_MAC:
						ld(cmd_k_i, `RAU_BLK, 1'b1, S_KEY);
					default:
						state_q <= S_DONE;
					endcase
				end
			end
			S_LOAD: begin
				case (sub_q)
				SB_ISSUE: begin
					ram_addr_o <= base_q + {7'h00, idx_q};
					ram_re_o <= 1'b1;
					sub_q <= SB_WAIT;
				end
				SB_WAIT:
					sub_q <= SB_TAKE;
				default: begin
					if (le_q)
						blk_q[bpos +: 8] <= ram_rdata_i;
					else
						blk_q[`RAU_TOPB - bpos +: 8] <= ram_rdata_i;
					idx_q <= idx_q + 5'h01;
					sub_q <= SB_ISSUE;
					if (idx_q == nb_q - 5'h01)
						state_q <= ret_q;
				end
				endcase
			end
			S_WRITE: begin
				ram_we_o <= 1'b1;
				ram_addr_o <= base_q + {7'h00, idx_q};
				ram_wdata_o <= le_q ? wbuf_q[bpos +: 8] : wbuf_q[`RAU_TOPB - bpos +: 8];
				idx_q <= idx_q + 5'h01;
				if (idx_q == nb_q - 5'h01)
					state_q <= ret_q;
			end
			S_BYTE: begin
				case (sub_q)
				SB_ISSUE: begin
					if (op_q == `RAU_OP_RXMOV) begin
						if (rx_valid_i) begin
							tmp_q <= rx_data_i;
							rx_pop_o <= 1'b1;
							sub_q <= SB_PUT;
						end
					end else begin
						ram_addr_o <= src_w;
						ram_re_o <= 1'b1;
						sub_q <= SB_WAIT;
					end
				end
				SB_WAIT:
					sub_q <= SB_TAKE;
				SB_TAKE: begin
					tmp_q <= ram_rdata_i;
					if (op_q == `RAU_OP_XCP) begin
						ram_addr_o <= dst_w;
						ram_re_o <= 1'b1;
						sub_q <= SB_XWAIT;
					end else
						sub_q <= SB_PUT;
				end
				SB_XWAIT:
					sub_q <= SB_XTAKE;
				SB_XTAKE: begin
					tmp_q <= tmp_q ^ ram_rdata_i;
					sub_q <= SB_PUT;
				end
				default: begin
					if (op_q != `RAU_OP_TXCP) begin
						ram_we_o <= 1'b1;
						ram_addr_o <= dst_w;
						ram_wdata_o <= tmp_q;
					end
					if ((op_q != `RAU_OP_TXCP) || !b1v_q) begin
						i_q <= i_q + 8'h01;
						sub_q <= SB_ISSUE;
						if (i_q == cnt_q - 8'h01)
							state_q <= S_DONE;
					end
				end
				endcase
			end
			// whole chunk read before any write
			S_RVL: begin
				if (fin_w)
					state_q <= S_DONE;
				else
					ld(a_q + {3'h0, off_q}, blen, 1'b1, S_RVW);
			end
			// byte n lands at end minus n
			S_RVW: begin
				wr(rv_base, blen, 1'b0, blk_q << {(`RAU_BLK - blen), 3'b000}, S_RVL);
				off_q <= off_q + `RAU_BLK9;
			end
			S_INCW:
				wr(a_q, cnt_q[4:0], 1'b1, blk_q + 128'h1, S_DONE);
			S_KEY: begin
				key_q <= blk_q;
				if ((op_q == `RAU_OP_ECB) || (op_q == `RAU_OP_BLOCK_ENCRYPT_IN_PLACE))
					ld(a_q, ecb_n, 1'b0, S_ENC);
				else
					ld(n_q, `RAU_BLK, 1'b1, S_CTR0);
			end
			// counter mode or MAC first block
			S_CTR0: begin
				ctr_q <= blk_q;
				if (op_q == `RAU_OP_MAC) begin
					wbuf_q <= {128{1'b0}};
					blk_q <= b0_w;
					state_q <= S_ENC;
				end else
					state_q <= S_BLK;
			end
			S_BLK: begin
				if (!fin_w)
					ld(a_q + {3'h0, off_q}, blen, 1'b0, S_ENC);
				else if ((op_q == `RAU_OP_MAC) && (m_q[1:0] != 2'h0))
					wr(e_q, tag_n, 1'b0, wbuf_q, S_DONE);
				else
					state_q <= S_DONE;
			end
			S_ENC: begin
				if (op_q == `RAU_OP_CTR)
					st_q <= ctr_q ^ key_q;
				else if (op_q == `RAU_OP_MAC)
					st_q <= blk_q ^ wbuf_q ^ key_q;
				else
					st_q <= blk_q ^ key_q;
				rk_q <= key_q;
				rcon_q <= `RAU_RCON0;
				rnd_q <= 4'h1;
				state_q <= S_AES;
			end
			S_AES: begin
				st_q <= rnd_w;
				rk_q <= rk_n;
				rcon_q <= xt(rcon_q);
				rnd_q <= rnd_q + 4'h1;
				if (rnd_q == `RAU_LAST_RND)
					state_q <= S_OUT;
			end
			S_OUT: begin
				case (op_q)
				`RAU_OP_CTR: begin
					wr(e_q + {3'h0, off_q}, blen, 1'b0, st_q ^ blk_q, S_BLK);
					ctr_q[15:0] <= ctr_q[15:0] + 16'h0001;
					off_q <= off_q + `RAU_BLK9;
				end
				`RAU_OP_MAC: begin
					wbuf_q <= st_q;
					first_q <= 1'b0;
					if (!first_q)
						off_q <= off_q + `RAU_BLK9;
					state_q <= S_BLK;
				end
				default:
					wr(ecb_ip ? a_q : e_q, ecb_ip ? `RAU_BLK : ecb_n, 1'b0, st_q, S_DONE);
				endcase
			end
			// wait for transmit buffer to drain
			S_DONE: begin
				if (!tx_valid_o && !b1v_q) begin
					done_o <= 1'b1;
					cmd_ready_o <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Two-entry transmit buffer; head drives the port
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h00;
			b1_q <= 8'h00;
			b1v_q <= 1'b0;
		end else if (ce_i) begin
			if (pop_w) begin
				if (b1v_q) begin
					tx_data_o <= b1_q;
					b1v_q <= 1'b0;
				end else if (push_w)
					tx_data_o <= tmp_q;
				else
					tx_valid_o <= 1'b0;
			end else if (push_w) begin
				if (!tx_valid_o) begin
					tx_data_o <= tmp_q;
					tx_valid_o <= 1'b1;
				end else begin
					b1_q <= tmp_q;
					b1v_q <= 1'b1;
				end
			end
		end
	end
endmodule

// ===== core/rau_consts.vh
`ifndef RAU_CONSTS_VH
`define RAU_CONSTS_VH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define RAU_OP_RXMOV  4'h1
`define RAU_OP_TXCP   4'h2
`define RAU_OP_CP     4'h3
`define RAU_OP_CPR    4'h4
`define RAU_OP_XCP    4'h5
`define RAU_OP_INC    4'h6
`define RAU_OP_ECB    4'h7
`define RAU_OP_BLOCK_ENCRYPT_IN_PLACE   4'h8
`define RAU_OP_CTR    4'h9
`define RAU_OP_MAC    4'ha

// ----------------------------------------
// Block and AES constants
// ----------------------------------------
`define RAU_BLK       5'h10
`define RAU_BLK9      9'h010
`define RAU_TOPB      7'h78
`define RAU_POLY      8'h1b
`define RAU_AFF       8'h63
`define RAU_RCON0     8'h01
`define RAU_LAST_RND  4'ha
`define RAU_MLUT0     3'h0
`define RAU_MLUT1     3'h1
`define RAU_MLUT2     3'h3
`define RAU_MLUT3     3'h7

`endif

// ===== core/rau_sbox.v
`timescale 1ns/1ps
module rau_sbox (
	// Byte in, substituted byte out
	input  wire [7:0] a_i,
	output wire [7:0] s_o
);
`include "rau_consts.vh"

	// GF(2^8) product, shift-and-add; avoids a 256-entry table per instance
	function [7:0] gm;
		input [7:0] x;
		input [7:0] y;
		integer     i;
		reg   [7:0] p;
		reg   [7:0] t;
		begin
			p = 8'h00;
			t = x;
			for (i = 0; i < 8; i = i + 1) begin
				if (y[i])
					p = p ^ t;
				t = {t[6:0], 1'b0} ^ (t[7] ? `RAU_POLY : 8'h00);
			end
			gm = p;
		end
	endfunction

	// Inverse as a^254 through an addition chain; zero maps to zero
	wire [7:0] x2   = gm(a_i, a_i);
	wire [7:0] x3   = gm(x2, a_i);
	wire [7:0] x6   = gm(x3, x3);
	wire [7:0] x12  = gm(x6, x6);
	wire [7:0] x15  = gm(x12, x3);
	wire [7:0] x30  = gm(x15, x15);
	wire [7:0] x60  = gm(x30, x30);
	wire [7:0] x120 = gm(x60, x60);
	wire [7:0] x240 = gm(x120, x120);
	wire [7:0] x252 = gm(x240, x12);
	wire [7:0] b    = gm(x252, x2);

	// Affine step
	assign s_o = b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]}
		^ {b[3:0], b[7:4]} ^ `RAU_AFF;
endmodule

// ===== verif/rau_core_chk.sv
`timescale 1ns/1ps
module rau_core_chk (
	// Clock, reset, enable
	input wire       sys_clk_i,
	input wire       rst_n_i,
	input wire       ce_i,
	// Instruction handshake
	input wire       cmd_valid_i,
	input wire       cmd_ready_o,
	input wire       done_o,
	// Memory and FIFO strobes
	input wire       ram_we_o,
	input wire       rx_valid_i,
	input wire       rx_pop_o,
	input wire       tx_valid_o,
	input wire [7:0] tx_data_o,
	input wire       tx_ready_i
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_take_busy: assert property (ce_i && cmd_valid_i && cmd_ready_o |=> !cmd_ready_o)
		else $error("ready stayed high after a take");
	a_done_single: assert property (done_o && ce_i |=> !done_o)
		else $error("done longer than one cycle");
	a_done_ready: assert property (done_o |-> cmd_ready_o)
		else $error("done without ready");
	a_ready_done: assert property ($rose(cmd_ready_o) |-> done_o)
		else $error("ready rose without done");
	a_done_bound: assert property ($fell(cmd_ready_o) |-> ##[1:1000] done_o)
		else $error("instruction never finished");
	// Idle means every write and FIFO move of the last instruction has landed
	a_idle_quiet: assert property (cmd_ready_o
		|-> !ram_we_o && !rx_pop_o && !tx_valid_o)
		else $error("activity while idle");
	a_pop_avail: assert property (rx_pop_o |-> $past(rx_valid_i))
		else $error("pop from empty receive fifo");
	a_tx_hold: assert property (tx_valid_o && !tx_ready_i && ce_i
		|=> tx_valid_o && $stable(tx_data_o))
		else $error("stalled transmit byte changed");
endmodule

bind rau_core rau_core_chk u_chk (
	.sys_clk_i  (sys_clk_i),
	.rst_n_i    (rst_n_i),
	.ce_i       (ce_i),
	.cmd_valid_i(cmd_valid_i),
	.cmd_ready_o(cmd_ready_o),
	.done_o     (done_o),
	.ram_we_o   (ram_we_o),
	.rx_valid_i (rx_valid_i),
	.rx_pop_o   (rx_pop_o),
	.tx_valid_o (tx_valid_o),
	.tx_data_o  (tx_data_o),
	.tx_ready_i (tx_ready_i)
);

// ===== verif/rau_mem_model.sv
`timescale 1ns/1ps
module rau_mem_model (
	// Clock and stall control
	input  wire        sys_clk_i,
	input  wire        stall_i,
	// RAM side
	input  wire [11:0] ram_addr_o,
	input  wire        ram_re_o,
	input  wire        ram_we_o,
	input  wire [7:0]  ram_wdata_o,
	output reg  [7:0]  ram_rdata_i = 8'h00,
	// FIFO sides
	output wire        rx_valid_i,
	output wire [7:0]  rx_data_i,
	input  wire        rx_pop_o,
	input  wire        tx_valid_o,
	input  wire [7:0]  tx_data_o,
	output wire        tx_ready_i
);
	reg [7:0] mem [0:4095];
	reg [7:0] rxq [0:63];
	reg [7:0] txq [0:63];
	reg [5:0] rp = 6'h00;
	reg [5:0] wp = 6'h00;
	reg [3:0] ph = 4'h0;
	integer   tn = 0;
	integer   wn = 0;

	// Sync RAM; stale read data is scrambled so late sampling shows up
	always @(posedge sys_clk_i) begin
		ram_rdata_i <= ram_re_o ? mem[ram_addr_o] : ~ram_rdata_i;
		if (ram_we_o) begin
			mem[ram_addr_o] <= ram_wdata_o;
			wn <= wn + 1;
		end
		if (rx_pop_o)
			rp <= rp + 6'h01;
		if (tx_valid_o && tx_ready_i) begin
			txq[tn[5:0]] <= tx_data_o;
			tn <= tn + 1;
		end
		ph <= ph + 4'h1;
	end

	// Empty fifo head is junk that changes every cycle
	assign rx_valid_i = rp != wp;
	assign rx_data_i  = rx_valid_i ? rxq[rp] : {ph, ~ph};
	assign tx_ready_i = !stall_i || ph[1];
endmodule

// ===== verif/rau_core_tb.sv
`timescale 1ns/1ps
`include "rau_consts.vh"
`define CHK(nm, e, g) begin \
	checks_done = checks_done + 1; \
	if ((g) !== (e)) begin \
		fails = fails + 1; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end \
end
module rau_core_tb;
	reg         sys_clk_i   = 1'b0;
	reg         rst_n_i     = 1'b0;
	reg         ce_i        = 1'b1;
	reg         cmd_valid_i = 1'b0;
	reg         stall       = 1'b0;
	reg  [3:0]  cmd_op_i    = 4'h0;
	reg  [7:0]  cmd_cnt_i   = 8'h00;
	reg  [11:0] cmd_a_i     = 12'h000;
	reg  [11:0] cmd_e_i     = 12'h000;
	reg  [11:0] cmd_k_i     = 12'h700;
	reg  [11:0] cmd_n_i     = 12'h720;
	reg  [2:0]  cmd_m_i     = 3'h0;
	// Published AES-128 known answer for key 00..0f and plaintext 00112233..ff
	reg [127:0] aes_kat     = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	wire        cmd_ready_o, done_o, ram_re_o, ram_we_o, rx_valid_i, rx_pop_o;
	wire        tx_valid_o, tx_ready_i;
	wire [11:0] ram_addr_o;
	wire [7:0]  ram_wdata_o, ram_rdata_i, rx_data_i, tx_data_o;
	integer     fails = 0, checks_done = 0, i, j, w0;

	rau_core u_rau_core (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_cnt_i(cmd_cnt_i),
		.cmd_a_i(cmd_a_i), .cmd_e_i(cmd_e_i), .cmd_k_i(cmd_k_i), .cmd_n_i(cmd_n_i),
		.cmd_m_i(cmd_m_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
		.ram_addr_o(ram_addr_o), .ram_re_o(ram_re_o), .ram_we_o(ram_we_o),
		.ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_rdata_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .rx_pop_o(rx_pop_o), .tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
	rau_mem_model u_mem (.sys_clk_i(sys_clk_i), .stall_i(stall), .ram_addr_o(ram_addr_o),
		.ram_re_o(ram_re_o), .ram_we_o(ram_we_o), .ram_wdata_o(ram_wdata_o),
		.ram_rdata_i(ram_rdata_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_pop_o(rx_pop_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_ready_i(tx_ready_i));

	always #10 sys_clk_i = ~sys_clk_i;

	task tally_and_finish;
		begin
			if (fails == 0 && checks_done > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// Issue one instruction while idle and wait, bounded, for its done pulse
	task go(input [3:0] op, input [7:0] c, input [11:0] a, input [11:0] e, input [2:0] m);
		integer t;
		begin
			@(negedge sys_clk_i);
			cmd_op_i = op;
			cmd_cnt_i = c;
			cmd_a_i = a;
			cmd_e_i = e;
			cmd_m_i = m;
			cmd_valid_i = 1'b1;
			@(negedge sys_clk_i);
			cmd_valid_i = 1'b0;
			for (t = 0; t < 3000 && done_o !== 1'b1; t = t + 1)
				@(negedge sys_clk_i);
			if (t == 3000) begin
				fails = fails + 1;
				tally_and_finish;
			end
		end
	endtask

	task t_copy;
		begin
			for (i = 0; i < 9; i = i + 1)
				u_mem.mem[12'h100 + i] = i[7:0] + 8'h01;
			go(`RAU_OP_CP, 8'h09, 12'h100, 12'h101, 3'h0);
			for (i = 0; i < 9; i = i + 1)
				`CHK("copy", i[7:0] + 8'h01, u_mem.mem[12'h101 + i])
		end
	endtask

	task t_rev;
		begin
			for (i = 0; i < 16; i = i + 1)
				u_mem.mem[12'h200 + i] = i[7:0] + 8'h10;
			go(`RAU_OP_CPR, 8'h10, 12'h200, 12'h200, 3'h0);
			for (i = 0; i < 16; i = i + 1)
				`CHK("rev", i[7:0] + 8'h10, u_mem.mem[12'h20f - i])
		end
	endtask

	task t_xor;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				u_mem.mem[12'h300 + i] = i[7:0] + 8'ha0;
				u_mem.mem[12'h310 + i] = i[7:0] * 8'h03;
			end
			u_mem.mem[12'h305] = 8'h77;
			go(`RAU_OP_XCP, 8'h05, 12'h300, 12'h310, 3'h0);
			for (i = 0; i < 5; i = i + 1)
				`CHK("xor", (i[7:0] + 8'ha0) ^ (i[7:0] * 8'h03), u_mem.mem[12'h310 + i])
			go(`RAU_OP_XCP, 8'h05, 12'h300, 12'h300, 3'h0);
			for (i = 0; i < 6; i = i + 1)
				`CHK("clr", (i == 5) ? 8'h77 : 8'h00, u_mem.mem[12'h300 + i])
		end
	endtask

	// widths 1, 2 and 4 only; three bytes is never requested
	task t_inc;
		begin
			for (j = 0; j < 3; j = j + 1) begin
				for (i = 0; i < (1 << j) - 1; i = i + 1)
					u_mem.mem[12'h330 + i] = 8'hff;
				u_mem.mem[12'h32f + (1 << j)] = 8'h12;
				u_mem.mem[12'h330 + (1 << j)] = 8'h55;
				go(`RAU_OP_INC, 8'h01 << j, 12'h330, 12'h000, 3'h0);
				for (i = 0; i <= (1 << j); i = i + 1) begin
					w0 = (i == (1 << j)) ? 8'h55 : (i == (1 << j) - 1) ? 8'h13 : 8'h00;
					`CHK("inc", w0[7:0], u_mem.mem[12'h330 + i])
				end
			end
		end
	endtask

	// Bytes arrive late, so the move must wait on an empty fifo
	task t_rx;
		begin
			for (i = 0; i < 4; i = i + 1)
				u_mem.rxq[i] = i[7:0] + 8'h40;
			u_mem.wp = 6'h02;
			fork
				go(`RAU_OP_RXMOV, 8'h04, 12'h000, 12'h400, 3'h0);
				begin
					repeat (30) @(negedge sys_clk_i);
					u_mem.wp = 6'h04;
				end
			join
			for (i = 0; i < 4; i = i + 1)
				`CHK("rx", i[7:0] + 8'h40, u_mem.mem[12'h400 + i])
			`CHK("rxpop", 6'h04, u_mem.rp)
		end
	endtask

	task t_tx;
		begin
			for (i = 0; i < 6; i = i + 1)
				u_mem.mem[12'h500 + i] = i[7:0] + 8'hc0;
			stall = 1'b1;
			go(`RAU_OP_TXCP, 8'h06, 12'h500, 12'h000, 3'h0);
			stall = 1'b0;
			`CHK("txn", 6, u_mem.tn)
			for (i = 0; i < 6; i = i + 1)
				`CHK("tx", i[7:0] + 8'hc0, u_mem.txq[i])
		end
	endtask

	// Short input with equal addresses still yields a full block
	// every output range stays clear of keys, counter and live data
	task t_enc;
		begin
			for (j = 0; j < 2; j = j + 1) begin
				w0 = u_mem.wn;
				go(j ? `RAU_OP_BLOCK_ENCRYPT_IN_PLACE : `RAU_OP_ECB, 8'h05, 12'h600, 12'h600, 3'h0);
				`CHK("encw", 16, u_mem.wn - w0)
			end
			// Known answer; key stored byte-reversed at its own address
			for (i = 0; i < 16; i = i + 1) begin
				u_mem.mem[12'h740 + i] = 8'h0f - i[7:0];
				u_mem.mem[12'h760 + i] = {i[3:0], i[3:0]};
			end
			cmd_k_i = 12'h740;
			go(`RAU_OP_ECB, 8'h10, 12'h760, 12'h780, 3'h0);
			cmd_k_i = 12'h700;
			for (i = 0; i < 16; i = i + 1)
				`CHK("ecb", aes_kat[127 - 8 * i -: 8], u_mem.mem[12'h780 + i])
		end
	endtask

	// Counter mode undoes itself; equal plaintext blocks differ once the counter steps
	task t_ctr;
		begin
			for (i = 0; i < 20; i = i + 1)
				u_mem.mem[12'h680 + i] = 8'h5a;
			w0 = u_mem.wn;
			go(`RAU_OP_CTR, 8'h14, 12'h680, 12'h6a0, 3'h0);
			`CHK("ctrw", 20, u_mem.wn - w0)
			w0 = {u_mem.mem[12'h6a0], u_mem.mem[12'h6a1], u_mem.mem[12'h6a2], u_mem.mem[12'h6a3]};
			j = {u_mem.mem[12'h6b0], u_mem.mem[12'h6b1], u_mem.mem[12'h6b2], u_mem.mem[12'h6b3]};
			`CHK("ctrstep", 1'b1, w0 !== j)
			go(`RAU_OP_CTR, 8'h14, 12'h6a0, 12'h6c0, 3'h0);
			for (i = 0; i < 20; i = i + 1)
				`CHK("ctr", 8'h5a, u_mem.mem[12'h6c0 + i])
		end
	endtask

	task t_mac;
		begin
			for (j = 0; j < 4; j = j + 1) begin
				w0 = u_mem.wn;
				go(`RAU_OP_MAC, 8'h05, 12'h600, 12'h640, j[2:0]);
				`CHK("macw", (j == 0) ? 0 : (2 << j), u_mem.wn - w0)
			end
		end
	endtask

	initial begin
		for (i = 0; i < 16; i = i + 1) begin
			u_mem.mem[12'h700 + i] = 8'hcf - i[7:0];
			u_mem.mem[12'h720 + i] = i[7:0];
		end
		repeat (3) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		t_copy;
		t_rev;
		t_xor;
		t_inc;
		t_rx;
		t_tx;
		t_enc;
		t_ctr;
		t_mac;
		tally_and_finish;
	end
endmodule
